/* design/micd_decoder.sv */
// top of the motion input command decoder: inputs to motion commands
module micd_decoder #(
   parameter int SETTLE_CYC = micd_pkg::EXC_SETTLE_CYC,
   parameter int DATA_NUM_W = 6
) (
   // clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   ce_i,
   // operation start, stop, free and excitation inputs
   input  wire logic                   home_start_i,
   input  wire logic                   forward_run_in_i,
   input  wire logic                   reverse_run_in_i,
   input  wire logic                   incremental_step_plus_in_i,
   input  wire logic                   incremental_step_minus_in_i,
   input  wire logic                   stop_i,
   input  wire logic                   free_i,
   input  wire logic                   exc_direct_i,
   input  wire logic                   exc_remote_i,
   input  wire logic [1:0]             exc_assign_i,
   input  wire logic                   brake_fitted_i,
   // home sensors
   input  wire logic                   sensor_in_a_i,
   input  wire logic                   phase_timing_signal_i,
   input  wire logic                   home_sensor_i,
   input  wire logic                   push_contact_i,
   // selected operation data
   input  wire logic [DATA_NUM_W-1:0]  data_num_i,
   input  wire logic [19:0]            data_speed_i,
   // settings
   input  wire logic [1:0]             home_mode_i,
   input  wire logic [19:0]            home_speed_i,
   input  wire logic [19:0]            home_start_speed_i,
   input  wire logic [19:0]            home_accel_i,
   input  wire logic                   home_dir_i,
   input  wire logic [23:0]            home_offset_i,
   input  wire logic                   home_sensor_in_a_en_i,
   input  wire logic                   home_tim_en_i,
   input  wire logic [9:0]             push_current_i,
   input  wire logic [22:0]            jog_travel_i,
   input  wire logic [19:0]            jog_speed_i,
   input  wire logic [19:0]            jog_start_speed_i,
   input  wire logic [19:0]            jog_accel_i,
   input  wire logic [1:0]             stop_action_i,
   // pulse generator status
   input  wire logic                   motor_stopped_i,
   input  wire logic                   move_done_i,
   // motion command
   output micd_pkg::micd_cmd_t         cmd_o,
   output logic                        cmd_dir_o,
   output logic [19:0]                 cmd_speed_o,
   output logic [19:0]                 cmd_start_speed_o,
   output logic [19:0]                 cmd_accel_o,
   output logic [23:0]                 cmd_travel_o,
   output logic [1:0]                  cmd_home_mode_o,
   output logic                        cmd_home_qual_o,
   output logic [9:0]                  cmd_current_limit_o,
   output logic                        cmd_clear_travel_o,
   // status and drive stage
   output logic                        home_done_o,
   output logic                        excite_o,
   output logic                        brake_release_o
);

   typedef enum {ST_IDLE, ST_HOME, ST_CONT, ST_JOG, ST_DECEL, ST_HALT} micd_state_t;

   micd_state_t         state_r;
   micd_state_t         state_nxt;
   logic                home_prev_r;
   logic                jogp_prev_r;
   logic                jogm_prev_r;
   logic                stop_cut_r;
   logic                exc_ready;
   logic                home_rise;
   logic                jogp_rise;
   logic                jogm_rise;
   logic                fwd_only;
   logic                rev_only;
   logic                both_run;
   logic                cont_dir_r;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // clamp a speed setting into 1..1,000,000 (or 0.. when zero is legal)
   function automatic logic [19:0] clamp_speed(input logic [19:0] v, input logic allow_zero);
      logic [19:0] r;
      r = v;
      if (v > micd_pkg::SPEED_MAX) begin
         r = micd_pkg::SPEED_MAX;
      end else if (v == 20'h0 && !allow_zero) begin
         r = 20'h1;
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // input edges and run decoding
   // ------------------------------------------------------------
   // home and jog start inputs act on their rising edge so a held level does not restart
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         home_prev_r <= 1'b0;
         jogp_prev_r <= 1'b0;
         jogm_prev_r <= 1'b0;
      end else if (ce_i) begin
         home_prev_r <= home_start_i;
         jogp_prev_r <= incremental_step_plus_in_i;
         jogm_prev_r <= incremental_step_minus_in_i;
      end
   end

   assign home_rise = home_start_i & ~home_prev_r;
   assign jogp_rise = incremental_step_plus_in_i & ~jogp_prev_r;
   assign jogm_rise = incremental_step_minus_in_i & ~jogm_prev_r;
   assign both_run  = forward_run_in_i & reverse_run_in_i;
   assign fwd_only  = forward_run_in_i & ~reverse_run_in_i;
   assign rev_only  = reverse_run_in_i & ~forward_run_in_i;

   // ------------------------------------------------------------
   // operation state machine
   // ------------------------------------------------------------
   // free overrides all, then stop; motion starts need excitation in place
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (stop_i) begin
               state_nxt = ST_IDLE;
            end else if (!exc_ready || free_i) begin
               state_nxt = ST_IDLE;
            end else if (home_rise) begin
               state_nxt = ST_HOME;
            end else if (fwd_only || rev_only) begin
               state_nxt = ST_CONT;
            end else if (jogp_rise || jogm_rise) begin
               state_nxt = ST_JOG;
            end
         end
         ST_CONT: begin
            if (stop_i) begin
               state_nxt = ST_HALT;
            end else if (both_run || (!fwd_only && !rev_only)) begin
               state_nxt = ST_DECEL;
            end else if (fwd_only != cont_dir_r) begin
               state_nxt = ST_DECEL;
            end
         end
         ST_DECEL: begin
            if (stop_i) begin
               state_nxt = ST_HALT;
            end else if ((fwd_only && cont_dir_r) || (rev_only && !cont_dir_r)) begin
               state_nxt = ST_CONT;
            end else if (motor_stopped_i) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_HOME, ST_JOG: begin
            if (stop_i) begin
               state_nxt = ST_HALT;
            end else if (move_done_i && motor_stopped_i) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_HALT: begin
            if (motor_stopped_i && !stop_i) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (free_i && state_r != ST_IDLE) begin
         state_nxt = ST_HALT;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else if (ce_i) begin
         state_r <= state_nxt;
      end
   end

   // direction latched at continuous start; opposite input decelerates first
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cont_dir_r <= 1'b1;
      end else if (ce_i && state_r == ST_IDLE && state_nxt == ST_CONT) begin
         cont_dir_r <= fwd_only;
      end
   end

   // ------------------------------------------------------------
   // home-complete flag
   // ------------------------------------------------------------
   // cleared when a new homing starts, set once it ends at rest
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         home_done_o <= 1'b0;
      end else if (ce_i) begin
         if (state_r == ST_HOME && state_nxt == ST_IDLE) begin
            home_done_o <= 1'b1;
         end else if (state_nxt == ST_HOME && state_r != ST_HOME) begin
            home_done_o <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // stop action and current cut
   // ------------------------------------------------------------
   // current-off actions hold the cut until the stop input falls
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         stop_cut_r <= 1'b0;
      end else if (ce_i) begin
         if (!stop_i) begin
            stop_cut_r <= 1'b0;
         end else if (motor_stopped_i || stop_action_i == micd_pkg::STOP_IMM_OFF) begin
            stop_cut_r <= stop_action_i[1];
         end
      end
   end

   // ------------------------------------------------------------
   // command outputs
   // ------------------------------------------------------------
   // registered so the pulse generator sees one stable word per cycle
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_o               <= micd_pkg::MICD_CMD_IDLE;
         cmd_dir_o           <= micd_pkg::HOME_DIR_RST;
         cmd_speed_o         <= 20'h0;
         cmd_start_speed_o   <= 20'h0;
         cmd_accel_o         <= 20'h0;
         cmd_travel_o        <= 24'h0;
         cmd_home_mode_o     <= micd_pkg::HOME_MODE_RST;
         cmd_home_qual_o     <= 1'b1;
         cmd_current_limit_o <= micd_pkg::PUSH_CUR_RST;
         cmd_clear_travel_o  <= 1'b0;
      end else if (ce_i) begin
         cmd_clear_travel_o <= stop_i && (state_r == ST_JOG || state_r == ST_HOME);
         case (state_nxt)
            ST_HOME: begin
               cmd_o             <= micd_pkg::MICD_CMD_HOME;
               cmd_dir_o         <= home_dir_i;
               cmd_speed_o       <= clamp_speed(home_speed_i, 1'b0);
               cmd_start_speed_o <= clamp_speed(home_start_speed_i, 1'b0);
               cmd_accel_o       <= clamp_speed(home_accel_i, 1'b0);
               cmd_travel_o      <= home_offset_i;
               cmd_home_mode_o   <= (home_mode_i > micd_pkg::HOME_MODE_PUSH) ?
                                    micd_pkg::HOME_MODE_RST : home_mode_i;
               // extra qualifiers gate the home sensor edge when enabled
               cmd_home_qual_o   <= (home_mode_i == micd_pkg::HOME_MODE_PUSH ? push_contact_i : home_sensor_i) &
                                    (sensor_in_a_i | ~home_sensor_in_a_en_i) &
                                    (phase_timing_signal_i | ~home_tim_en_i);
               cmd_current_limit_o <= (home_mode_i == micd_pkg::HOME_MODE_PUSH) ?
                                      ((push_current_i > micd_pkg::PUSH_CUR_MAX) ?
                                       micd_pkg::PUSH_CUR_MAX : push_current_i) :
                                      micd_pkg::PUSH_CUR_MAX;
            end
            ST_CONT: begin
               cmd_o             <= micd_pkg::MICD_CMD_CONT;
               cmd_dir_o         <= (state_r == ST_IDLE) ? fwd_only : cont_dir_r;
               cmd_speed_o       <= clamp_speed(data_speed_i, 1'b0);
               cmd_travel_o      <= 24'h0;
               cmd_current_limit_o <= micd_pkg::PUSH_CUR_MAX;
            end
            ST_JOG: begin
               if (state_r != ST_JOG) begin
                  cmd_o             <= micd_pkg::MICD_CMD_JOG;
                  cmd_dir_o         <= jogp_rise;
                  cmd_speed_o       <= clamp_speed(jog_speed_i, 1'b0);
                  cmd_start_speed_o <= clamp_speed(jog_start_speed_i, 1'b1);
                  cmd_accel_o       <= clamp_speed(jog_accel_i, 1'b0);
                  cmd_travel_o      <= {1'b0, (jog_travel_i == 23'h0) ?
                                        micd_pkg::JOG_TRAVEL_RST : jog_travel_i};
                  cmd_current_limit_o <= micd_pkg::PUSH_CUR_MAX;
               end
            end
            ST_DECEL: begin
               cmd_o <= micd_pkg::MICD_CMD_DECEL;
            end
            ST_HALT: begin
               cmd_o <= (stop_action_i[0] && !free_i) ?
                        micd_pkg::MICD_CMD_DECEL : micd_pkg::MICD_CMD_HALT;
            end
            default: begin
               cmd_o <= micd_pkg::MICD_CMD_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // shaft holding
   // ------------------------------------------------------------
   micd_shaft_ctl #(
      .SETTLE_CYC      (SETTLE_CYC)
   ) u_shaft (
      .ref_clk_i       (ref_clk_i),
      .rst_i           (rst_i),
      .ce_i            (ce_i),
      .exc_assign_i    (exc_assign_i),
      .exc_direct_i    (exc_direct_i),
      .exc_remote_i    (exc_remote_i),
      .free_i          (free_i),
      .stop_cut_i      (stop_cut_r),
      .brake_fitted_i  (brake_fitted_i),
      .excite_o        (excite_o),
      .brake_release_o (brake_release_o),
      .exc_ready_o     (exc_ready)
   );

endmodule // micd_decoder

/* design/micd_pkg.sv */
// constants, settings layout and enumerations of the motion input command decoder
package micd_pkg;

   // ------------------------------------------------------------
   // setting ranges and reset values
   // ------------------------------------------------------------
   localparam logic [1:0]  HOME_MODE_2SNS = 2'h0;
   localparam logic [1:0]  HOME_MODE_3SNS = 2'h1;
   localparam logic [1:0]  HOME_MODE_PUSH = 2'h2;
   localparam logic [1:0]  HOME_MODE_RST  = HOME_MODE_3SNS;
   localparam logic [19:0] SPEED_MAX      = 20'hf4240;   // 1,000,000 Hz
   localparam logic [19:0] HOME_SPD_RST   = 20'h003e8;   // 1,000 Hz
   localparam logic [19:0] HOME_SSPD_RST  = 20'h001f4;   // 500 Hz
   localparam logic [19:0] HOME_ACC_RST   = 20'h003e8;   // 1,000
   localparam logic        HOME_DIR_RST   = 1'h1;        // positive
   localparam logic [23:0] HOME_OFS_RST   = 24'h000000;
   localparam logic [9:0]  PUSH_CUR_MAX   = 10'h3e8;     // 100.0 %
   localparam logic [9:0]  PUSH_CUR_RST   = 10'h3e8;
   localparam logic [22:0] JOG_TRAVEL_MAX = 23'h7fffff;  // 8,388,607 steps
   localparam logic [22:0] JOG_TRAVEL_RST = 23'h000001;
   localparam logic [19:0] JOG_SPD_RST    = 20'h003e8;
   localparam logic [19:0] JOG_SSPD_RST   = 20'h001f4;
   localparam logic [1:0]  STOP_ACT_RST   = 2'h1;

   // ------------------------------------------------------------
   // stop actions and excitation source assignment
   // ------------------------------------------------------------
   localparam logic [1:0]  STOP_IMM       = 2'h0;
   localparam logic [1:0]  STOP_DEC       = 2'h1;
   localparam logic [1:0]  STOP_IMM_OFF   = 2'h2;
   localparam logic [1:0]  STOP_DEC_OFF   = 2'h3;
   localparam int          EXC_DIRECT_BIT = 0;
   localparam int          EXC_REMOTE_BIT = 1;
   // cycles from excitation on to brake release (20 ns each)
   localparam int          EXC_SETTLE_NS  = 100000;
   localparam int          CLK_PERIOD_NS  = 20;
   localparam int          EXC_SETTLE_CYC = (EXC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // motion commands toward the pulse generator
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MICD_CMD_IDLE,
      MICD_CMD_HOME,
      MICD_CMD_CONT,
      MICD_CMD_JOG,
      MICD_CMD_DECEL,
      MICD_CMD_HALT
   } micd_cmd_t;

endpackage

/* design/micd_shaft_ctl.sv */
// excitation, brake and free-shaft control of the motion input command decoder
module micd_shaft_ctl #(
   parameter int SETTLE_CYC = micd_pkg::EXC_SETTLE_CYC
) (
   // clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // excitation request sources, free, stop cut and brake fitted
   input  wire logic [1:0] exc_assign_i,
   input  wire logic       exc_direct_i,
   input  wire logic       exc_remote_i,
   input  wire logic       free_i,
   input  wire logic       stop_cut_i,
   input  wire logic       brake_fitted_i,
   // drive stage
   output logic            excite_o,
   output logic            brake_release_o,
   output logic            exc_ready_o
);

   logic        exc_req;
   logic        exc_nxt;
   logic [31:0] settle_r;

   // ------------------------------------------------------------
   // effective excitation request
   // ------------------------------------------------------------
   // an unassigned source counts as on, so both-assigned means both needed
   always_comb begin
      exc_req = (exc_direct_i | ~exc_assign_i[micd_pkg::EXC_DIRECT_BIT]) &
                (exc_remote_i | ~exc_assign_i[micd_pkg::EXC_REMOTE_BIT]);
      exc_nxt = exc_req & ~free_i & ~stop_cut_i;
   end

   // motor current on when requested, unless freed or cut by a current-off stop
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         excite_o <= 1'b0;
      end else if (ce_i) begin
         excite_o <= exc_nxt;
      end
   end

   // settle count so the brake, outside free, never lets go of an unheld shaft
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         settle_r <= 32'h0;
      end else if (ce_i) begin
         if (!excite_o) begin
            settle_r <= 32'h0;
         end else if (settle_r < 32'(SETTLE_CYC)) begin
            settle_r <= settle_r + 32'h1;
         end
      end
   end

   assign exc_ready_o = excite_o && (settle_r >= 32'(SETTLE_CYC));

   // brake: released when none is fitted, when free, or once excitation is established
   // and stays on next cycle, so the brake grips in the same edge that current drops
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         brake_release_o <= 1'b0;
      end else if (ce_i) begin
         brake_release_o <= ~brake_fitted_i | free_i | (exc_ready_o & exc_nxt);
      end
   end

endmodule // micd_shaft_ctl

/* verif/micd_checker.sv */
// port-level assertions of the motion input command decoder
module micd_checker (
   // clock, reset and host levels
   input wire logic                 ref_clk_i, rst_i, stop_i, free_i,
   input wire logic                 forward_run_in_i, reverse_run_in_i, incremental_step_plus_in_i,
   input wire logic                 motor_stopped_i, move_done_i,
   input wire logic [19:0]          data_speed_i,
   input wire logic [1:0]           stop_action_i,
   // decoder outputs
   input wire logic                 cmd_dir_o, home_done_o, excite_o, brake_release_o,
   input wire logic [19:0]          cmd_speed_o,
   input wire micd_pkg::micd_cmd_t  cmd_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // -------------------------------------------------------------
   // assertions, all in the single clock domain
   // -------------------------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   chk_free_cuts: assert property (free_i |=> !excite_o)
      else $error("free input left current on");
   chk_brake_order: assert property (brake_release_o && !free_i && !$past(free_i) |-> excite_o)
      else $error("brake released without excitation");
   chk_cont_speed: assert property (cmd_o == micd_pkg::MICD_CMD_CONT && $past(cmd_o) == micd_pkg::MICD_CMD_CONT
      |-> cmd_speed_o == $past(data_speed_i)) else $error("run speed not following data");
   chk_cont_dir: assert property (cmd_o == micd_pkg::MICD_CMD_CONT && $past(cmd_o) == micd_pkg::MICD_CMD_IDLE
      |-> cmd_dir_o == $past(forward_run_in_i)) else $error("run direction wrong");
   chk_both_decel: assert property (cmd_o == micd_pkg::MICD_CMD_CONT && forward_run_in_i && reverse_run_in_i
      && !stop_i && !free_i |=> cmd_o == micd_pkg::MICD_CMD_DECEL) else $error("both runs kept going");
   chk_stop_kind: assert property (cmd_o == micd_pkg::MICD_CMD_CONT && stop_i && !free_i |=> cmd_o ==
      ($past(stop_action_i[0]) ? micd_pkg::MICD_CMD_DECEL : micd_pkg::MICD_CMD_HALT)) else $error("stop kind");
   chk_home_done: assert property (cmd_o == micd_pkg::MICD_CMD_HOME && move_done_i && motor_stopped_i && !stop_i
      && !free_i |=> cmd_o == micd_pkg::MICD_CMD_IDLE && home_done_o) else $error("home completion");
   chk_imm_off: assert property ($past(stop_i) && $past(cmd_o) == micd_pkg::MICD_CMD_CONT && stop_i
      && stop_action_i == 2'h2 |=> !excite_o) else $error("current kept after stop");
   chk_jog_dir: assert property (cmd_o == micd_pkg::MICD_CMD_JOG && $past(cmd_o) == micd_pkg::MICD_CMD_IDLE
      |-> cmd_dir_o == $past(incremental_step_plus_in_i)) else $error("jog direction wrong");
   // main scenarios reached
   cov_decel: cover property (cmd_o == micd_pkg::MICD_CMD_CONT ##1 cmd_o == micd_pkg::MICD_CMD_DECEL);
   cov_home: cover property (home_done_o);
   cov_jog: cover property (cmd_o == micd_pkg::MICD_CMD_JOG);
endmodule // micd_checker

/* verif/micd_host_model.sv */
// host controller model that drives the decoder's start and stop levels
module micd_host_model (
   input  wire logic       ref_clk_i,
   input  wire logic [6:0] req_i,
   output logic      [6:0] lines_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // a scanning host updates its outputs just after its own edge, never on it
   initial lines_o = 7'h00;
   always @(posedge ref_clk_i) lines_o <= #1 req_i;
endmodule // micd_host_model

/* verif/tb_micd_decoder.sv */
// self-checking testbench of the motion input command decoder
module tb_micd_decoder;
   timeunit 1ns;
   timeprecision 100ps;
   logic                ref_clk_i = 1'b0, rst_i = 1'b1;
   logic [6:0]          req = 7'h00, ln;
   logic [19:0]         sp = 20'h00100, hs = 20'h003e8, spd, ssp;
   logic [23:0]         trv;
   logic [9:0]          cur;
   logic [1:0]          sa = 2'h1, ea = 2'h3, hmo;
   logic                hd = 1'b0, xd = 1'b1, xr = 1'b0, mst = 1'b1, mdn = 1'b0, dir, hdn, exc, brk;
   int                  fail_count = 0, checks_done = 0;
   micd_pkg::micd_cmd_t cmd;
   always #10 ref_clk_i = ~ref_clk_i;
   // line bits: free, stop, jog minus, jog plus, reverse, forward, home
   micd_host_model u_micd_host_model (.ref_clk_i(ref_clk_i), .req_i(req), .lines_o(ln));
   micd_decoder #(.SETTLE_CYC(4)) u_micd_decoder (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .home_start_i(ln[0]), .forward_run_in_i(ln[1]), .reverse_run_in_i(ln[2]), .incremental_step_plus_in_i(ln[3]),
      .incremental_step_minus_in_i(ln[4]), .stop_i(ln[5]), .free_i(ln[6]), .exc_direct_i(xd), .exc_remote_i(xr),
      .exc_assign_i(ea), .brake_fitted_i(1'b1), .sensor_in_a_i(mdn), .phase_timing_signal_i(mdn),
      .home_sensor_i(mdn), .push_contact_i(mdn), .data_num_i(sp[5:0]), .data_speed_i(sp), .home_mode_i(sa),
      .home_speed_i(hs), .home_start_speed_i(hs), .home_accel_i(hs), .home_dir_i(hd), .home_offset_i({4'h0, hs}),
      .home_sensor_in_a_en_i(hd), .home_tim_en_i(hd), .push_current_i(hs[9:0]), .jog_travel_i({3'h0, hs}),
      .jog_speed_i(hs), .jog_start_speed_i(hs), .jog_accel_i(hs), .stop_action_i(sa), .motor_stopped_i(mst),
      .move_done_i(mdn), .cmd_o(cmd), .cmd_dir_o(dir), .cmd_speed_o(spd), .cmd_start_speed_o(ssp),
      .cmd_accel_o(), .cmd_travel_o(trv), .cmd_home_mode_o(hmo), .cmd_home_qual_o(), .cmd_current_limit_o(cur),
      .cmd_clear_travel_o(), .home_done_o(hdn), .excite_o(exc), .brake_release_o(brk));
   // -------------------------------------------------------------
   // shared helpers
   // -------------------------------------------------------------
   task automatic ck(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic st(input int k);
      repeat (k) @(posedge ref_clk_i);
      #1;
   endtask
   // bounded waits; running out ends the run at once
   task automatic wt(input micd_pkg::micd_cmd_t c);
      for (int n = 0; n < 40 && cmd !== c; n++) st(1);
      ck(cmd === c, "command never arrived");
      if (cmd !== c) complete_run();
   endtask
   task automatic wb();
      for (int n = 0; n < 40 && brk !== 1'b1; n++) st(1);
      ck(brk === 1'b1 && exc === 1'b1, "brake not released after excitation");
      if (brk !== 1'b1) complete_run();
   endtask
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_excite();
      st(8);
      ck(exc === 1'b0 && brk === 1'b0, "one source of two excited");
      xr = 1'b1;
      wb();
      $display("test excite done");
   endtask
   task automatic t_cont();
      mst = 1'b0;
      req = 7'h02;
      wt(micd_pkg::MICD_CMD_CONT);
      ck(dir === 1'b1 && spd === sp, "forward run");
      sp = 20'h00200;
      st(2);
      ck(spd === 20'h00200, "speed switch");
      req = 7'h06;
      wt(micd_pkg::MICD_CMD_DECEL);
      req = 7'h00;
      st(2);
      req = 7'h02;
      wt(micd_pkg::MICD_CMD_CONT);
      req = 7'h00;
      mst = 1'b1;
      wt(micd_pkg::MICD_CMD_IDLE);
      $display("test run done");
   endtask
   // every stop action; a reason to keep the motor moving is that action 3 waits for rest
   task automatic t_stop();
      for (int a = 0; a < 4; a++) begin
         sa = a[1:0];
         mst = 1'b0;
         req = 7'h02;
         wt(micd_pkg::MICD_CMD_CONT);
         req = 7'h22;
         wt(a[0] ? micd_pkg::MICD_CMD_DECEL : micd_pkg::MICD_CMD_HALT);
         st(2);
         ck(exc === (a != 2), "current after stop");
         req = 7'h00;
         mst = 1'b1;
         wt(micd_pkg::MICD_CMD_IDLE);
         wb();
      end
      sa = 2'h1;
      $display("test stop done");
   endtask
   task automatic t_home();
      mst = 1'b0;
      req = 7'h01;
      wt(micd_pkg::MICD_CMD_HOME);
      ck(dir === 1'b0 && spd === hs, "home settings");
      ck(ssp === hs && trv === {4'h0, hs} && hmo === 2'h1 && cur === 10'h3e8, "home setup");
      req = 7'h00;
      mdn = 1'b1;
      mst = 1'b1;
      wt(micd_pkg::MICD_CMD_IDLE);
      ck(hdn === 1'b1, "home not complete");
      mdn = 1'b0;
      $display("test home done");
   endtask
   task automatic t_jog();
      for (int i = 0; i < 2; i++) begin
         mst = 1'b0;
         req = i ? 7'h08 : 7'h10;
         wt(micd_pkg::MICD_CMD_JOG);
         ck(dir === i[0] && trv === {4'h0, hs} && ssp === hs, "jog move");
         req = 7'h00;
         mdn = 1'b1;
         mst = 1'b1;
         wt(micd_pkg::MICD_CMD_IDLE);
         mdn = 1'b0;
      end
      $display("test jog done");
   endtask
   task automatic t_free();
      mst = 1'b0;
      req = 7'h02;
      wt(micd_pkg::MICD_CMD_CONT);
      req = 7'h42;
      wt(micd_pkg::MICD_CMD_HALT);
      st(1);
      ck(exc === 1'b0, "free kept current");
      req = 7'h00;
      mst = 1'b1;
      wt(micd_pkg::MICD_CMD_IDLE);
      wb();
      $display("test free done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      t_excite();
      t_cont();
      t_stop();
      t_home();
      t_jog();
      t_free();
      complete_run();
   end
endmodule // tb_micd_decoder
bind micd_decoder micd_checker u_micd_checker (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .stop_i(stop_i),
   .free_i(free_i), .forward_run_in_i(forward_run_in_i), .reverse_run_in_i(reverse_run_in_i),
   .incremental_step_plus_in_i(incremental_step_plus_in_i), .motor_stopped_i(motor_stopped_i),
   .move_done_i(move_done_i), .data_speed_i(data_speed_i), .stop_action_i(stop_action_i),
   .cmd_dir_o(cmd_dir_o), .home_done_o(home_done_o), .excite_o(excite_o),
   .brake_release_o(brake_release_o), .cmd_speed_o(cmd_speed_o), .cmd_o(cmd_o));
